// ===== hdl/telegram_defs.svh
// constants for the telegram status and control byte handling
`ifndef TELEGRAM_DEFS_SVH
`define TELEGRAM_DEFS_SVH
`define STAT_SERVICE_BIT 2
`define STAT_LOSS_BIT 5
`define STAT_TOGGLE_BIT 7
`define CTRL_COMMAND_BIT 0
`define CTRL_BROADCAST_BIT 1
`define CTRL_ADDR_LSB 2
`define CTRL_ADDR_MSB 6
`define CTRL_TOGGLE_BIT 7
`define STATUS_RESET 8'h00
`define LENGTH_RESET 8'h00
`define CONTROL_RESET 8'h00
`define MAX_LENGTH 8'hFF
`define BCAST_CHAR0 8'h30
`define BCAST_CHAR1 8'h30
`define BCAST_CHAR2 8'h42
`endif

// ===== hdl/telegram_pkg.sv
// types shared by the telegram framer
package telegram_pkg;
    typedef enum logic [1:0] {
        tx_idle = 2'b00,
        tx_pre0 = 2'b01,
        tx_pre1 = 2'b11,
        tx_pre2 = 2'b10
    } tx_state_t;
    typedef enum logic [1:0] {
        sw_run = 2'b00,
        sw_gateway = 2'b01,
        sw_end_unit = 2'b10
    } switch_pos_t;
endpackage

// ===== hdl/pin_sync.sv
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/1ps
module pin_sync (
    input wire logic clock,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clock) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end else begin
            s1_reg <= pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // level moves only once the last two stages agree
    always_ff @(posedge clock) begin
        if (rst) begin
            level <= 1'b0;
        end else if (s2_reg == s3_reg) begin
            level <= s3_reg;
        end
    end
endmodule

// ===== hdl/telegram_framer.sv
// status and control byte handling for fieldbus telegrams
// Notes on behaviour
// [R01] service flag is one while the switch is in a service position
// [R02] service flag clears once the switch returns to run
// [R03] loss flag sets when data for the plc is discarded
// [R04] overlong data is truncated to configured length and loss flag set
// [R05] toggle bit inverts per data set delivered in transparent mode
// [R06] status byte one holds the user byte count, reset zero
// [R07] control byte layout: command, broadcast, five-bit address, toggle
// [R08] command mode blocks plc data to the serial end device
// [R09] in command mode, set data bits trigger serial commands
// [R10] broadcast and address ignored without a multidrop concentrator
// [R11] broadcast with concentrator prefixes the broadcast command
// [R12] only user data after the two header bytes goes to the end device
// [R13] status and count are zero after reset until first telegram; the service and loss flags here can set before any telegram
`timescale 1ns/1ps
`include "telegram_defs.svh"
module telegram_framer
    import telegram_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    // service switch pins
    input wire logic gateway_service_position,
    input wire logic end_unit_service_position,
    // strap: multidrop concentrator on the serial side
    input wire logic concentrator_present,
    // configured telegram user data length
    input wire logic [7:0] config_length,
    input wire logic transparent_mode,
    // inbound data set from the end device toward the plc
    input wire logic in_valid,
    input wire logic [7:0] in_length,
    input wire logic in_drop,
    // control bytes written by the plc
    input wire logic ctrl_write,
    input wire logic [7:0] control_flags,
    input wire logic [7:0] control_reserved,
    // plc data byte stream toward the end device
    input wire logic plc_valid,
    input wire logic [7:0] plc_data,
    output logic plc_ready,
    // serial side byte stream
    output logic ser_valid,
    output logic [7:0] ser_data,
    input wire logic ser_ready,
    output logic [7:0] cmd_trigger,
    output logic cmd_valid,
    // status bytes toward the plc
    output logic [7:0] status_flags,
    output logic [7:0] user_data_length,
    output logic [7:0] control_readback,
    output logic [4:0] station_address,
    output logic telegram_out
);
    logic gw_lvl;
    logic dev_lvl;
    logic service_flag_reg;
    logic loss_flag_reg;
    logic new_data_toggle_reg;
    logic [7:0] user_byte_count_reg;
    logic [7:0] control_reg;
    logic [7:0] byte_count_next;
    logic overlong;
    logic pre_bcast;
    tx_state_t state_reg;
    tx_state_t state_next;

    pin_sync sync_gw (
        .clock(clock),
        .rst(rst),
        .pin(gateway_service_position),
        .level(gw_lvl)
    );
    pin_sync sync_dev (
        .clock(clock),
        .rst(rst),
        .pin(end_unit_service_position),
        .level(dev_lvl)
    );

    // service flag follows the filtered switch
    always_ff @(posedge clock) begin
        if (rst) begin
            service_flag_reg <= 1'b0; // R13
        end else begin
            service_flag_reg <= gw_lvl | dev_lvl; // R01 R02
        end
    end

    // truncate to configured length; zero length configured means full range
    always_comb begin
        overlong = (config_length != 8'h00) && (in_length > config_length);
        byte_count_next = overlong ? config_length : in_length; // R04
    end

    // loss flag is sticky; nothing documented clears it except reset
    always_ff @(posedge clock) begin
        if (rst) begin
            loss_flag_reg <= 1'b0;
        end else if (in_drop || (in_valid && overlong)) begin
            loss_flag_reg <= 1'b1; // R03 R04
        end
    end

    // per data set: count and toggle
    always_ff @(posedge clock) begin
        if (rst) begin
            user_byte_count_reg <= `LENGTH_RESET; // R13
            new_data_toggle_reg <= 1'b0;
            telegram_out <= 1'b0;
        end else begin
            telegram_out <= in_valid;
            if (in_valid) begin
                user_byte_count_reg <= byte_count_next; // R06
                if (transparent_mode) begin
                    new_data_toggle_reg <= ~new_data_toggle_reg; // R05
                end
            end
        end
    end

    // status byte assembly, reserved bits read zero
    always_comb begin
        status_flags = `STATUS_RESET;
        status_flags[`STAT_SERVICE_BIT] = service_flag_reg;
        status_flags[`STAT_LOSS_BIT] = loss_flag_reg;
        status_flags[`STAT_TOGGLE_BIT] = new_data_toggle_reg;
        user_data_length = user_byte_count_reg;
    end

    // control byte latch; the reserved byte is accepted and dropped
    always_ff @(posedge clock) begin
        if (rst) begin
            control_reg <= `CONTROL_RESET;
        end else if (ctrl_write) begin
            control_reg <= control_flags; // R07
        end
    end
    assign control_readback = control_reg;

    // address only meaningful with a concentrator; zero otherwise
    always_comb begin
        if (concentrator_present) begin
            station_address = control_reg[`CTRL_ADDR_MSB:`CTRL_ADDR_LSB]; // R07 R10
        end else begin
            station_address = 5'b0_0000; // R10
        end
        pre_bcast = concentrator_present && control_reg[`CTRL_BROADCAST_BIT]; // R11 R10
    end

    // broadcast prefix sequencer: three bytes go out ahead of a data run
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            tx_idle: begin
                if (plc_valid && !control_reg[`CTRL_COMMAND_BIT] && pre_bcast) begin
                    state_next = tx_pre0; // R11
                end
            end
            tx_pre0: begin
                if (ser_ready) begin
                    state_next = tx_pre1;
                end
            end
            tx_pre1: begin
                if (ser_ready) begin
                    state_next = tx_pre2;
                end
            end
            tx_pre2: begin
                if (ser_ready) begin
                    state_next = tx_idle;
                end
            end
            default: state_next = tx_idle;
        endcase
    end

    // prefix is re-sent before each byte run; a run ends when plc_valid drops
    logic in_run_reg;
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= tx_idle;
            in_run_reg <= 1'b0;
        end else begin
            if (state_reg == tx_idle && in_run_reg) begin
                state_reg <= tx_idle;
            end else begin
                state_reg <= state_next;
            end
            if (!plc_valid) begin
                in_run_reg <= 1'b0;
            end else if (state_reg == tx_pre2 && ser_ready) begin
                in_run_reg <= 1'b1;
            end
        end
    end

    // serial output mux: prefix bytes, then user data only
    // follows state_reg directly so byte and valid always stand together; a register
    // here would lag the pass-through valid and repeat the previous plc byte
    always_comb begin
        case (state_reg)
            tx_pre0: ser_data = `BCAST_CHAR0;
            tx_pre1: ser_data = `BCAST_CHAR1;
            tx_pre2: ser_data = `BCAST_CHAR2;
            default: ser_data = plc_data; // R12
        endcase
    end

    // data path: command mode swallows plc bytes and raises triggers
    always_comb begin
        if (control_reg[`CTRL_COMMAND_BIT]) begin
            plc_ready = 1'b1; // R08
            ser_valid = 1'b0; // R08
        end else if (state_reg != tx_idle) begin
            plc_ready = 1'b0;
            ser_valid = 1'b1;
        end else if (pre_bcast && !in_run_reg) begin
            plc_ready = 1'b0;
            ser_valid = 1'b0;
        end else begin
            plc_ready = ser_ready;
            ser_valid = plc_valid; // R12
        end
    end

    // trigger byte registered so the command table sees a stable value
    always_ff @(posedge clock) begin
        if (rst) begin
            cmd_trigger <= 8'h00;
            cmd_valid <= 1'b0;
        end else begin
            cmd_valid <= control_reg[`CTRL_COMMAND_BIT] && plc_valid && (plc_data != 8'h00);
            if (control_reg[`CTRL_COMMAND_BIT] && plc_valid) begin
                cmd_trigger <= plc_data; // R09
            end
        end
    end
endmodule

// ===== testbench/telegram_framer_sva.sv
// port assertions for the telegram framer
`timescale 1ns/1ps
module telegram_framer_sva (
    input wire logic clock,
    input wire logic rst,
    input wire logic gateway_service_position,
    input wire logic end_unit_service_position,
    input wire logic concentrator_present,
    input wire logic [7:0] config_length,
    input wire logic transparent_mode,
    input wire logic in_valid,
    input wire logic [7:0] in_length,
    input wire logic in_drop,
    input wire logic ser_valid,
    input wire logic [7:0] cmd_trigger,
    input wire logic cmd_valid,
    input wire logic [7:0] status_flags,
    input wire logic [7:0] user_data_length,
    input wire logic [7:0] control_readback,
    input wire logic [4:0] station_address,
    input wire logic telegram_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // eight cycles covers the synchroniser plus filter latency
    sequence s_sw_on;
        (gateway_service_position || end_unit_service_position) [*8];
    endsequence
    sequence s_sw_off;
        (!gateway_service_position && !end_unit_service_position) [*8];
    endsequence
    wire over = in_valid && config_length != 8'h00 && in_length > config_length;
    AST_SVC_SET: assert property (s_sw_on |-> status_flags[2])
        else $error("service flag stays low");
    AST_SVC_CLR: assert property (s_sw_off |-> !status_flags[2])
        else $error("service flag stays high");
    AST_LOSS: assert property (in_drop |=> status_flags[5])
        else $error("loss flag not set");
    AST_LOSS_HOLD: assert property (status_flags[5] |=> status_flags[5])
        else $error("loss flag dropped");
    AST_TRUNC: assert property (over |=> user_data_length == $past(config_length)
        && status_flags[5])
        else $error("overlong set not truncated");
    AST_LEN: assert property (in_valid && !over |=> user_data_length == $past(in_length))
        else $error("length count wrong");
    AST_TOGGLE: assert property (in_valid && transparent_mode
        |=> status_flags[7] != $past(status_flags[7]))
        else $error("toggle did not invert");
    AST_CMD: assert property (control_readback[0] |-> !ser_valid)
        else $error("serial data in command mode");
    AST_TRIG: assert property (cmd_valid |-> cmd_trigger != 8'h00)
        else $error("empty trigger");
    AST_ADDR: assert property (!concentrator_present |-> station_address == 5'h00)
        else $error("address without concentrator");
    AST_ZERO: assert property ($fell(rst) |-> status_flags == 8'h00
        && user_data_length == 8'h00)
        else $error("status not zero after reset");
    AST_TEL: assert property (in_valid |=> telegram_out)
        else $error("no telegram after data set");
endmodule
bind telegram_framer telegram_framer_sva chk (
    .clock(clock),
    .rst(rst),
    .gateway_service_position(gateway_service_position),
    .end_unit_service_position(end_unit_service_position),
    .concentrator_present(concentrator_present),
    .config_length(config_length),
    .transparent_mode(transparent_mode),
    .in_valid(in_valid),
    .in_length(in_length),
    .in_drop(in_drop),
    .ser_valid(ser_valid),
    .cmd_trigger(cmd_trigger),
    .cmd_valid(cmd_valid),
    .status_flags(status_flags),
    .user_data_length(user_data_length),
    .control_readback(control_readback),
    .station_address(station_address),
    .telegram_out(telegram_out)
);

// ===== testbench/plc_model.sv
// plc side: control byte writes and the plc data byte stream
`timescale 1ns/1ps
module plc_model (
    input wire logic clock,
    input wire logic plc_ready,
    output logic ctrl_write,
    output logic [7:0] control_flags,
    output logic [7:0] control_reserved,
    output logic plc_valid,
    output logic [7:0] plc_data
);
    // reserved byte carries junk on purpose, the device must ignore it
    initial begin
        ctrl_write = 1'b0;
        control_flags = 8'h00;
        control_reserved = 8'h5a;
        plc_valid = 1'b0;
        plc_data = 8'h00;
    end
    task automatic write_ctrl(input logic cmd, input logic bc, input logic [4:0] adr);
        @(posedge clock);
        #2;
        control_flags = {1'b0, adr, bc, cmd};
        ctrl_write = 1'b1;
        @(posedge clock);
        #2;
        ctrl_write = 1'b0;
    endtask
    // held until an edge sees ready, bounded so a stuck device cannot hang us
    task automatic send(input logic [7:0] b);
        int n;
        n = 0;
        @(posedge clock);
        #2;
        plc_valid = 1'b1;
        plc_data = b;
        do begin
            @(negedge clock);
            n++;
        end while (plc_ready !== 1'b1 && n < 40);
        @(posedge clock);
        #2;
        plc_valid = 1'b0;
    endtask
endmodule

// ===== testbench/telegram_framer_tb_top.sv
// self-checking bench for the telegram framer
`timescale 1ns/1ps
module telegram_framer_tb_top;
    logic clock = 0, rst = 1, gw = 0, eu = 0, conc = 0, tm = 1, iv = 0, idrop = 0, sr = 0;
    logic [7:0] cfg = 8'h08, ilen = 8'h00, trig_seen = 8'h00;
    logic [15:0] ser_hist = 16'h0000;
    wire ctrl_write, plc_valid, plc_ready, ser_valid, cmd_valid, telegram_out;
    wire [7:0] control_flags, control_reserved, plc_data, ser_data, cmd_trigger;
    wire [7:0] status_flags, user_data_length, control_readback;
    wire [4:0] station_address;
    int fails = 0, tests_run = 0, ser_n = 0;
    telegram_framer dut (.clock(clock), .rst(rst), .gateway_service_position(gw),
        .end_unit_service_position(eu), .concentrator_present(conc), .config_length(cfg),
        .transparent_mode(tm), .in_valid(iv), .in_length(ilen), .in_drop(idrop),
        .ctrl_write(ctrl_write), .control_flags(control_flags),
        .control_reserved(control_reserved), .plc_valid(plc_valid), .plc_data(plc_data),
        .plc_ready(plc_ready), .ser_valid(ser_valid), .ser_data(ser_data), .ser_ready(sr),
        .cmd_trigger(cmd_trigger), .cmd_valid(cmd_valid), .status_flags(status_flags),
        .user_data_length(user_data_length), .control_readback(control_readback),
        .station_address(station_address), .telegram_out(telegram_out));
    plc_model plc (.clock(clock), .plc_ready(plc_ready), .ctrl_write(ctrl_write),
        .control_flags(control_flags), .control_reserved(control_reserved),
        .plc_valid(plc_valid), .plc_data(plc_data));
    initial begin
        forever #12.5 clock = ~clock;
    end
    // serial side stalls every other cycle; handshakes counted and bytes kept mid-cycle
    always @(posedge clock) sr <= #2 ~sr;
    always @(negedge clock) begin
        if (ser_valid === 1'b1 && sr === 1'b1) begin
            ser_n++;
            ser_hist = {ser_hist[7:0], ser_data};
        end
        if (cmd_valid === 1'b1) trig_seen = cmd_trigger;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic test_done();
        if (fails == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic t_reset();
        rst = 1'b1;
        repeat (8) @(posedge clock);
        #2 rst = 1'b0;
        @(negedge clock);
        chk(status_flags, 8'h00);
        chk(user_data_length, 8'h00);
    endtask
    task automatic t_service();
        @(posedge clock);
        #2 gw = 1'b1;
        repeat (8) @(posedge clock);
        chk(status_flags & 8'h04, 8'h04);
        #2 gw = 1'b0;
        repeat (8) @(posedge clock);
        chk(status_flags & 8'h04, 8'h00);
        #2 eu = 1'b1;
        repeat (8) @(posedge clock);
        chk(status_flags & 8'h04, 8'h04);
        #2 eu = 1'b0;
        repeat (8) @(posedge clock);
    endtask
    task automatic t_drop();
        @(posedge clock);
        #2 idrop = 1'b1;
        @(posedge clock);
        #2 idrop = 1'b0;
        chk(status_flags, 8'h20);
        chk(8'(telegram_out), 8'h00);
    endtask
    // back-to-back data sets: overlong then short, toggle flips each time
    task automatic t_length();
        @(posedge clock);
        #2 iv = 1'b1;
        ilen = 8'h14;
        @(posedge clock);
        #2 ilen = 8'h03;
        chk(user_data_length, 8'h08);
        chk(status_flags, 8'ha0);
        chk(8'(telegram_out), 8'h01);
        @(posedge clock);
        #2 iv = 1'b0;
        chk(user_data_length, 8'h03);
        chk(status_flags, 8'h20);
        // a set outside transparent mode must leave the toggle alone
        @(posedge clock);
        #2 tm = 1'b0;
        iv = 1'b1;
        ilen = 8'h05;
        @(posedge clock);
        #2 iv = 1'b0;
        tm = 1'b1;
        chk(user_data_length, 8'h05);
        chk(status_flags, 8'h20);
    endtask
    task automatic t_cmd();
        int n0;
        n0 = ser_n;
        plc.write_ctrl(1'b1, 1'b0, 5'h00);
        chk(control_readback, 8'h01);
        plc.send(8'h02);
        repeat (6) @(posedge clock);
        chk(trig_seen, 8'h02);
        chk(8'(ser_n - n0), 8'h00);
        plc.write_ctrl(1'b0, 1'b0, 5'h00);
    endtask
    task automatic t_bcast(input logic c, input logic [7:0] exp_n);
        int n0;
        @(posedge clock);
        #2 conc = c;
        plc.write_ctrl(1'b0, 1'b1, 5'h13);
        chk(control_readback, 8'h4e);
        chk(8'(station_address), c ? 8'h13 : 8'h00);
        n0 = ser_n;
        plc.send(8'h41);
        repeat (8) @(posedge clock);
        chk(8'(ser_n - n0), exp_n);
        chk(ser_hist[7:0], 8'h41);
        chk(ser_hist[15:8], c ? 8'h42 : 8'h41);
    endtask
    initial begin
        #20000;
        fails++;
        test_done();
    end
    initial begin
        t_reset();
        t_service();
        t_drop();
        t_reset();
        t_length();
        t_cmd();
        t_bcast(1'b1, 8'h04);
        t_bcast(1'b0, 8'h01);
        test_done();
    end
endmodule
